// ### lvc_pkg.sv
// lvc_pkg: register map, field layouts and timing constants for the
// record-path automatic level control configuration block.
// assumes a single 10 MHz core clock and an 8-bit register port.
`default_nettype none
package lvc_pkg;
	// register addresses on the serial control port (7-bit)
	localparam logic [6:0] ADDR_MODE = 7'h7b;
	localparam logic [6:0] ADDR_THR_TIME = 7'h7c;
	localparam logic [6:0] ADDR_RESTART_GAIN = 7'h7d;
	// reset values (all controls off)
	localparam logic [7:0] MODE_RST = 8'h00;
	localparam logic [7:0] THR_TIME_RST = 8'h00;
	localparam logic [7:0] UNMAPPED_RD = 8'h00;
	// recovery mode codes
	localparam logic [1:0] REC_NONE = 2'h0;
	localparam logic [1:0] REC_NORMAL = 2'h1;
	localparam logic [1:0] REC_LIMITED = 2'h2;
	// sample rate codes (host keeps 2'h3 unused)
	localparam logic [1:0] RATE_96K = 2'h0;
	localparam logic [1:0] RATE_48K = 2'h1;
	localparam logic [1:0] RATE_32K = 2'h2;
	// limited recovery counter limits
	localparam logic [4:0] LIM_0 = 5'h03;
	localparam logic [4:0] LIM_1 = 5'h07;
	localparam logic [4:0] LIM_2 = 5'h0f;
	localparam logic [4:0] LIM_3 = 5'h1f;
	// thresholds as dB below full scale
	localparam logic [7:0] RTH_0 = 8'h02;
	localparam logic [7:0] RTH_1 = 8'h03;
	localparam logic [7:0] RTH_2 = 8'h04;
	localparam logic [7:0] RTH_3 = 8'h06;
	localparam logic [7:0] ATH_0 = 8'h00;
	localparam logic [7:0] ATH_1 = 8'h01;
	localparam logic [7:0] ATH_2 = 8'h02;
	localparam logic [7:0] ATH_3 = 8'h04;
	// timer periods in ms
	localparam logic [8:0] REC_MS_0 = 9'h020;
	localparam logic [8:0] REC_MS_1 = 9'h040;
	localparam logic [8:0] REC_MS_2 = 9'h080;
	localparam logic [8:0] REC_MS_3 = 9'h100;
	localparam logic [8:0] ATK_MS_0 = 9'h001;
	localparam logic [8:0] ATK_MS_1 = 9'h004;
	// clock period and one millisecond, both in ns
	localparam int unsigned CLK_PERIOD_NS = 100;
	localparam int unsigned MS_NS = 1000000;
	localparam logic [7:0] GAIN_MAX = 8'hff;
	// first control register layout
	typedef struct packed {
		logic [1:0] rate_select;
		logic [1:0] recovery_count_limit;
		logic [1:0] recovery_mode_select;
		logic limit_detect_mode;
		logic level_control_enable;
	} lvc_mode_t;
	// second control register layout
	typedef struct packed {
		logic reserved;
		logic [1:0] recovery_threshold;
		logic [1:0] attack_threshold;
		logic [1:0] recovery_time_select;
		logic attack_time_select;
	} lvc_thr_time_t;
endpackage
`default_nettype wire

// ### lvc_core.sv
// lvc_core: level control registers plus the gain reduction stepper.
// assumes the serial control port decoder delivers one-cycle read and
// write strobes on core_clk, and that level meters on core_clk report
// per-channel peak as dB below full scale with a one-cycle valid.
//
// Operation
// - limited recovery bounded by counter limit field
// - mode field picks none, normal, limited recovery
// - detect on either channel, or both channels
// - level control acts only while enabled
// - first register layout at 0x7B
// - second register layout at 0x7C, bit7 reserved
// - threshold codes decode to fixed dB levels
// - recovery and attack step periods per code
// - third register is restart and readback only
// - any write to third register restarts
// - reading third register returns gain reduction
`default_nettype none
module lvc_core #(
	parameter int unsigned MS_TICK_CYCLES = lvc_pkg::MS_NS / lvc_pkg::CLK_PERIOD_NS
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic [6:0] reg_addr,
	input wire logic reg_wr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_rd,
	input wire logic [7:0] lvl_left_db,
	input wire logic [7:0] lvl_right_db,
	input wire logic lvl_valid,
	output logic [7:0] reg_rdata,
	output logic reg_rvalid,
	output logic [7:0] gain_reduction,
	output logic [1:0] rate_select
);
	// threshold decode, used by detector and by checks
	function automatic logic [7:0] rec_thr_db(input logic [1:0] c);
		unique case (c)
			2'h0: rec_thr_db = lvc_pkg::RTH_0;
			2'h1: rec_thr_db = lvc_pkg::RTH_1;
			2'h2: rec_thr_db = lvc_pkg::RTH_2;
			2'h3: rec_thr_db = lvc_pkg::RTH_3;
		endcase
	endfunction
	function automatic logic [7:0] atk_thr_db(input logic [1:0] c);
		unique case (c)
			2'h0: atk_thr_db = lvc_pkg::ATH_0;
			2'h1: atk_thr_db = lvc_pkg::ATH_1;
			2'h2: atk_thr_db = lvc_pkg::ATH_2;
			2'h3: atk_thr_db = lvc_pkg::ATH_3;
		endcase
	endfunction
	function automatic logic [4:0] count_limit(input logic [1:0] c);
		unique case (c)
			2'h0: count_limit = lvc_pkg::LIM_0;
			2'h1: count_limit = lvc_pkg::LIM_1;
			2'h2: count_limit = lvc_pkg::LIM_2;
			2'h3: count_limit = lvc_pkg::LIM_3;
		endcase
	endfunction
	function automatic logic [8:0] rec_period_ms(input logic [1:0] c);
		unique case (c)
			2'h0: rec_period_ms = lvc_pkg::REC_MS_0;
			2'h1: rec_period_ms = lvc_pkg::REC_MS_1;
			2'h2: rec_period_ms = lvc_pkg::REC_MS_2;
			2'h3: rec_period_ms = lvc_pkg::REC_MS_3;
		endcase
	endfunction

	lvc_pkg::lvc_mode_t mode_r; // first control register
	lvc_pkg::lvc_thr_time_t thr_r; // second control register
	logic [7:0] gain_r; // current gain reduction, 1 dB steps
	logic [13:0] tick_cnt_r; // ms prescaler
	logic ms_tick_r; // one-cycle ms strobe
	logic [8:0] atk_cnt_r; // attack timer in ms
	logic [8:0] rec_cnt_r; // recovery timer in ms
	logic [4:0] rstep_r; // recovery steps since last attack
	logic over_r; // latest sample over attack threshold
	logic under_r; // latest sample under recovery threshold
	logic [7:0] rdata_r;
	logic rvalid_r;

	// register decode
	wire wr_mode = reg_wr && reg_addr == lvc_pkg::ADDR_MODE;
	wire wr_thr = reg_wr && reg_addr == lvc_pkg::ADDR_THR_TIME;
	wire restart = reg_wr && reg_addr == lvc_pkg::ADDR_RESTART_GAIN;
	wire enabled = mode_r.level_control_enable;
	wire [7:0] rd_mux = (reg_addr == lvc_pkg::ADDR_MODE) ? mode_r :
		(reg_addr == lvc_pkg::ADDR_THR_TIME) ? thr_r :
		(reg_addr == lvc_pkg::ADDR_RESTART_GAIN) ? gain_r :
		lvc_pkg::UNMAPPED_RD;

	// level detection; smaller dB figure means louder
	wire [7:0] atk_db = atk_thr_db(thr_r.attack_threshold);
	wire [7:0] rec_db = rec_thr_db(thr_r.recovery_threshold);
	wire left_over = lvl_left_db <= atk_db;
	wire right_over = lvl_right_db <= atk_db;
	wire sample_over = mode_r.limit_detect_mode ? (left_over && right_over) :
		(left_over || right_over);
	wire sample_under = lvl_left_db >= rec_db && lvl_right_db >= rec_db;

	// step timing
	wire [8:0] atk_ms = thr_r.attack_time_select ? lvc_pkg::ATK_MS_1 :
		lvc_pkg::ATK_MS_0;
	wire [8:0] rec_ms = rec_period_ms(thr_r.recovery_time_select);
	wire [4:0] lim = count_limit(mode_r.recovery_count_limit);
	wire [1:0] rmode = mode_r.recovery_mode_select;
	// recovery allowed by mode; 2'h3 behaves as no recovery
	wire rec_allowed = (rmode == lvc_pkg::REC_NORMAL) ||
		(rmode == lvc_pkg::REC_LIMITED && rstep_r < lim);
	wire atk_due = over_r && ms_tick_r && atk_cnt_r >= atk_ms - 9'h001;
	wire rec_due = !over_r && under_r && rec_allowed && gain_r != 8'h00 &&
		ms_tick_r && rec_cnt_r >= rec_ms - 9'h001;

	// register writes; reserved bit 7 of second register held at zero
	always_ff @(posedge core_clk) begin
		if (rst) begin
			mode_r <= lvc_pkg::MODE_RST;
			thr_r <= lvc_pkg::THR_TIME_RST;
		end else begin
			if (wr_mode) begin
				mode_r <= reg_wdata;
			end
			if (wr_thr) begin
				thr_r <= {1'b0, reg_wdata[6:0]};
			end
		end
	end

	// read port: data one cycle after strobe
	always_ff @(posedge core_clk) begin
		if (rst) begin
			rdata_r <= 8'h00;
			rvalid_r <= 1'b0;
		end else begin
			rvalid_r <= reg_rd;
			if (reg_rd) begin
				rdata_r <= rd_mux;
			end
		end
	end

	// ms prescaler free-runs so timers stay coarse but cheap
	always_ff @(posedge core_clk) begin
		if (rst || tick_cnt_r == 14'(MS_TICK_CYCLES - 1)) begin
			tick_cnt_r <= 14'h0000;
		end else begin
			tick_cnt_r <= tick_cnt_r + 14'h0001;
		end
	end
	always_ff @(posedge core_clk) begin
		if (rst) begin
			ms_tick_r <= 1'b0;
		end else begin
			ms_tick_r <= tick_cnt_r == 14'(MS_TICK_CYCLES - 1);
		end
	end

	// detector flags follow the latest meter sample
	always_ff @(posedge core_clk) begin
		if (rst || !enabled || restart) begin
			over_r <= 1'b0;
			under_r <= 1'b0;
		end else if (lvl_valid) begin
			over_r <= sample_over;
			under_r <= sample_under;
		end
	end

	// attack and recovery timers
	always_ff @(posedge core_clk) begin
		if (rst || !enabled || restart) begin
			atk_cnt_r <= 9'h000;
			rec_cnt_r <= 9'h000;
		end else begin
			if (!over_r || atk_due) begin
				atk_cnt_r <= 9'h000;
			end else if (ms_tick_r) begin
				atk_cnt_r <= atk_cnt_r + 9'h001;
			end
			// a loud sample, a blocked mode or a new period restarts the wait,
			// so the first step after recovery is allowed again is never early
			if (over_r || !under_r || !rec_allowed || gain_r == 8'h00 || wr_thr || rec_due) begin
				rec_cnt_r <= 9'h000;
			end else if (ms_tick_r) begin
				rec_cnt_r <= rec_cnt_r + 9'h001;
			end
		end
	end

	// gain stepper; attack wins over recovery, saturates at both ends
	always_ff @(posedge core_clk) begin
		if (rst || !enabled || restart) begin
			gain_r <= 8'h00;
			rstep_r <= 5'h00;
		end else if (atk_due) begin
			if (gain_r != lvc_pkg::GAIN_MAX) begin
				gain_r <= gain_r + 8'h01;
			end
			rstep_r <= 5'h00;
		end else if (rec_due) begin
			gain_r <= gain_r - 8'h01;
			if (rstep_r != lvc_pkg::LIM_3) begin
				rstep_r <= rstep_r + 5'h01;
			end
		end
	end

	assign reg_rdata = rdata_r;
	assign reg_rvalid = rvalid_r;
	assign gain_reduction = gain_r;
	assign rate_select = mode_r.rate_select;

	// checks
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (rst);

	chk_disable_zero: assert property (!enabled |=> gain_r == 8'h00)
		else $error("gain reduction not zero while disabled");
	chk_restart_clear: assert property (restart |=>
		atk_cnt_r == 9'h000 && rec_cnt_r == 9'h000 && rstep_r == 5'h00 && gain_r == 8'h00)
		else $error("restart did not clear timers");
	chk_read_gain: assert property (reg_rd && reg_addr == lvc_pkg::ADDR_RESTART_GAIN
		|=> reg_rvalid && reg_rdata == $past(gain_r))
		else $error("third register read did not return gain");
	chk_no_recovery: assert property (rmode == lvc_pkg::REC_NONE && !restart && enabled
		|=> gain_r >= $past(gain_r))
		else $error("gain recovered in no-recovery mode");
	chk_limit_bound: assert property (rmode == lvc_pkg::REC_LIMITED && rstep_r >= lim
		&& !restart && enabled |=> gain_r >= $past(gain_r))
		else $error("recovery past counter limit");
	chk_mode_layout: assert property (wr_mode |=> mode_r == $past(reg_wdata))
		else $error("first register write not stored");
	chk_thr_layout: assert property (wr_thr |=> thr_r == {1'b0, $past(reg_wdata[6:0])})
		else $error("second register layout wrong");
	chk_either_detect: assert property (enabled && !restart && lvl_valid
		&& !mode_r.limit_detect_mode && (left_over || right_over) |=> over_r)
		else $error("single channel over limit not detected");
	chk_attack_time: assert property (enabled && !restart && gain_r < lvc_pkg::GAIN_MAX
		&& over_r && ms_tick_r && atk_cnt_r == atk_ms - 9'h001 |=> gain_r == $past(gain_r) + 8'h01)
		else $error("attack step not taken at timer end");
	chk_rec_time: assert property ($fell(gain_r != 8'h00) || $past(gain_r) > gain_r
		|-> $past(rec_cnt_r) == $past(rec_ms) - 9'h001 || $past(!enabled || restart || rst))
		else $error("recovery step off its period");
endmodule
`default_nettype wire

// ### lvc_host.sv
// lvc_host: register-port master standing in for the control port host.
// assumes core_clk from the bench; all changes land on the falling edge.
`default_nettype none
module lvc_host (
	input wire logic core_clk,
	output logic [6:0] reg_addr,
	output logic reg_wr,
	output logic [7:0] reg_wdata,
	output logic reg_rd,
	input wire logic reg_rvalid,
	input wire logic [7:0] reg_rdata
);
	timeunit 1ns;
	timeprecision 1ns;
	// idle bus at time zero
	initial begin
		reg_addr = 7'h00;
		reg_wr = 1'b0;
		reg_wdata = 8'h00;
		reg_rd = 1'b0;
	end
	// one-cycle write strobe; address and data inverted once released
	task automatic write(input logic [6:0] a, input logic [7:0] d);
		@(negedge core_clk);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(negedge core_clk);
		reg_wr = 1'b0;
		reg_addr = ~a;
		reg_wdata = ~d;
	endtask
	// one-cycle read strobe, then a bounded wait for the valid pulse
	task automatic read(input logic [6:0] a, output logic [7:0] d, output logic ok);
		@(negedge core_clk);
		reg_addr = a;
		reg_rd = 1'b1;
		@(negedge core_clk);
		reg_rd = 1'b0;
		reg_addr = ~a;
		for (int n = 0; n < 3 && reg_rvalid !== 1'b1; n++) begin
			@(negedge core_clk);
		end
		ok = reg_rvalid;
		d = reg_rdata;
	endtask
endmodule
`default_nettype wire

// ### auto_level_control_config_test.sv
// auto_level_control_config_test: register and gain checks for lvc_core.
// assumes lvc_core with a 4-cycle ms tick so timer expectations stay short.
`default_nettype none
module auto_level_control_config_test;
	timeunit 1ns;
	timeprecision 1ns;
	logic core_clk = 1'b0;
	logic rst = 1'b1;
	logic [6:0] reg_addr;
	logic reg_wr, reg_rd, reg_rvalid;
	logic [7:0] reg_wdata, reg_rdata, gain_reduction, rdv, g;
	logic lvl_valid = 1'b0;
	logic [7:0] lvl_left_db = 8'h00;
	logic [7:0] lvl_right_db = 8'h00;
	logic [1:0] rate_select;
	int fails = 0;
	int checked = 0;
	// small tick: one ms is four clocks here
	lvc_core #(.MS_TICK_CYCLES(4)) i_dut (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr),
		.reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd), .lvl_left_db(lvl_left_db),
		.lvl_right_db(lvl_right_db), .lvl_valid(lvl_valid), .reg_rdata(reg_rdata),
		.reg_rvalid(reg_rvalid), .gain_reduction(gain_reduction), .rate_select(rate_select));
	lvc_host i_host (.core_clk(core_clk), .reg_addr(reg_addr), .reg_wr(reg_wr),
		.reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rvalid(reg_rvalid), .reg_rdata(reg_rdata));
	// 100 ns period
	always #50 core_clk = ~core_clk;
	// compare and count
	task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
		checked++;
		if (got !== exp) begin
			fails++;
			$display("Error %s expected %h seen %h", name, exp, got);
		end
	endtask
	// read through the host and compare both valid and data
	task automatic rdchk(input logic [6:0] a, input logic [7:0] exp, input string name);
		logic ok;
		i_host.read(a, rdv, ok);
		chk({name, "_valid"}, 8'h01, {7'h00, ok});
		chk(name, exp, rdv);
	endtask
	// one meter sample, both channels together
	task automatic meter(input logic [7:0] l, input logic [7:0] r);
		@(negedge core_clk);
		lvl_left_db = l;
		lvl_right_db = r;
		lvl_valid = 1'b1;
		@(negedge core_clk);
		lvl_valid = 1'b0;
	endtask
	task automatic idle(input int n);
		repeat (n) @(negedge core_clk);
	endtask
	task automatic conclude;
		if (fails == 0 && checked > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	// watchdog: whole run needs well under 4000 clocks
	initial begin
		#(8000 * 100);
		fails++;
		conclude();
	end
	initial begin
		idle(10);
		rst = 1'b0;
		chk("gain_rst", 8'h00, gain_reduction);
		rdchk(7'h7b, 8'h00, "mode_rst");
		rdchk(7'h7c, 8'h00, "thr_rst");
		rdchk(7'h10, 8'h00, "unmapped");
		// every legal rate code, with the other fields busy
		for (int i = 0; i < 3; i++) begin
			i_host.write(7'h7b, {i[1:0], 6'h2a});
			chk("rate_select", {6'h00, i[1:0]}, {6'h00, rate_select});
			rdchk(7'h7b, {i[1:0], 6'h2a}, "mode_rd");
		end
		i_host.write(7'h7c, 8'hff);
		rdchk(7'h7c, 8'h7f, "thr_reserved");
		// 0 dB attack, 1 ms; both channels needed, mode none
		i_host.write(7'h7c, 8'h00);
		i_host.write(7'h7b, 8'h03);
		meter(8'h00, 8'h14);
		idle(40);
		chk("gain_one_ch", 8'h00, gain_reduction);
		meter(8'h00, 8'h00);
		idle(60);
		meter(8'h1e, 8'h1e);
		g = gain_reduction;
		chk("gain_up", 8'h01, {7'h00, g > 8'h04});
		idle(300);
		chk("no_recovery", g, gain_reduction);
		rdchk(7'h7d, g, "gain_rd");
		// limited recovery, limit code 00 allows three steps
		i_host.write(7'h7b, 8'h0b);
		idle(700);
		chk("limited", g - 8'h03, gain_reduction);
		i_host.write(7'h7b, 8'h07);
		idle(200);
		chk("normal_rec", 8'h01, {7'h00, gain_reduction < g - 8'h03});
		i_host.write(7'h7d, 8'h5a);
		chk("restart", 8'h00, gain_reduction);
		// disabled: full-scale input must not attenuate
		i_host.write(7'h7b, 8'h02);
		meter(8'h00, 8'h00);
		idle(60);
		chk("disabled", 8'h00, gain_reduction);
		// -4 dB attack threshold, 4 ms attack, either channel
		i_host.write(7'h7c, 8'h19);
		i_host.write(7'h7b, 8'h01);
		meter(8'h03, 8'h28);
		idle(40);
		g = gain_reduction;
		chk("atk_slow", 8'h01, {7'h00, g >= 8'h01 && g <= 8'h03});
		// -6 dB recovery threshold: 5 dB holds, 6 dB recovers one step
		i_host.write(7'h7c, 8'h79);
		meter(8'h05, 8'h05);
		g = gain_reduction;
		i_host.write(7'h7b, 8'h07);
		idle(200);
		chk("rec_thr_hold", g, gain_reduction);
		meter(8'h06, 8'h06);
		idle(200);
		chk("rec_thr_step", g - 8'h01, gain_reduction);
		// reserved recovery mode must not recover
		i_host.write(7'h7b, 8'h0f);
		idle(200);
		chk("rec_mode_rsv", g - 8'h01, gain_reduction);
		// mid-run reset returns registers and gain to zero
		idle(1);
		rst = 1'b1;
		idle(2);
		rst = 1'b0;
		chk("gain_rst2", 8'h00, gain_reduction);
		rdchk(7'h7b, 8'h00, "mode_rst2");
		rdchk(7'h7c, 8'h00, "thr_rst2");
		conclude();
	end
endmodule
`default_nettype wire
